/* File: hw/gtpf_framer.sv */
// Summary of operation
// - one time-report frame starts on every internal one-hertz tick
// - no sentence yet: time from 2020-05-20 00:00:00, one second a tick
// - a PPS rising edge restarts the internal tick, locking its phase
// - valid RMC sentences supply real date and time, GGA sentences time only, to both packets
// - at the tick, stamped time is last sentence time plus one second
// - with GPS lost, ticks continue and time advances from the tick alone
// - IP destination is limited broadcast, source the default address
// - MAC destination all ones, own source MAC, EtherType IPv4
// - UDP source port 10000, destination port 10110
// - UDP length field is 520
// - time block: marker, date, second/minute/hour, four reserved
// - then sentence copy, fill, fix status byte, pulse lock flag, four reserved bytes
// - microsecond counter clears to zero on every PPS rising edge
// - sentence lock lost after two seconds without a valid sentence
`timescale 1ns/1ps
`default_nettype none
module gtpf_framer
   import gtpf_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC_DEF,
   parameter int unsigned NMEA_LOSS   = NMEA_CYC_DEF,
   parameter int unsigned PPS_LOSS    = PPS_CYC_DEF,
   parameter logic [47:0] SRC_MAC     = 48'h02_00_00_00_00_01, // arbitrary
   parameter logic [31:0] SRC_IP      = 32'hc0a801c9
)(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // receiver side
   input  wire logic        ppsPin,
   input  wire logic        nmeaValid,
   input  wire logic [7:0]  nmeaByte,
   input  wire logic        nmeaSelGga,
   // frame stream to the MAC
   input  wire logic        txReady,
   output logic             txValid,
   output logic [7:0]       txData,
   output logic             txLast,
   // time and status for the point-cloud path
   output logic [31:0]      usTime,
   output logic [5:0][6:0]  curTime,
   output logic             pulseLockFlag,
   output logic             nmeaLocked
);
   localparam int HDR_BITS = HDR_LEN * 8;
   localparam logic [15:0] IP_CSUM = gtpf_ip_csum(SRC_IP);
   localparam logic [HDR_BITS-1:0] HDR = {48'hffff_ffff_ffff, SRC_MAC,
      ETHERTYPE, IP_VER, 8'h00, IP_TOTLEN, 32'h0, IP_TTL, IP_PROTO,
      IP_CSUM, SRC_IP, DST_IP, UDP_SRC, UDP_DST, UDP_LEN,
      16'h0000};

   // widen before the product so the tens digit cannot overflow 4 bits
   function automatic logic [6:0] dig2(input logic [3:0] t,
                                       input logic [3:0] o);
      return 7'(t) * 7'h0a + 7'(o);
   endfunction

   // pps synchroniser, tick and microsecond timebase
   logic ppsMeta, ppsSync, ppsPrev, ppsRise;
   logic [31:0] tickCnt, next_tickCnt, ppsAge, next_ppsAge, next_usTime;
   logic [7:0]  usDiv, next_usDiv;
   logic        tick, next_tick, tickDly, next_pulseLockFlag;

   assign ppsRise = ppsSync & ~ppsPrev;

   always_comb begin
      next_tick = 1'b0;
      next_tickCnt = tickCnt + 32'h1;
      if (ppsRise || tickCnt == 32'(TICK_CYCLES - 1)) begin
         next_tick = 1'b1;
         next_tickCnt = 32'h0;
      end
      next_usDiv = (usDiv == US_CYC - 8'h1) ? 8'h0 : usDiv + 8'h1;
      next_usTime = (usDiv == US_CYC - 8'h1) ? usTime + 32'h1 : usTime;
      if (ppsRise) begin
         next_usDiv = 8'h0;
         next_usTime = 32'h0;
      end
      next_ppsAge = ppsRise ? 32'h0 : ppsAge + 32'(ppsAge != PPS_LOSS);
      next_pulseLockFlag = ppsRise | (pulseLockFlag && ppsAge != PPS_LOSS);
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         {ppsMeta, ppsSync, ppsPrev, tick, tickDly} <= 5'h0;
         tickCnt <= 32'h0;
         usDiv <= 8'h0;
         usTime <= 32'h0;
         ppsAge <= 32'h0;
         pulseLockFlag <= 1'b0;
      end else begin
         ppsMeta <= ppsPin;
         ppsSync <= ppsMeta;
         ppsPrev <= ppsSync;
         tick <= next_tick;
         tickDly <= tick;
         tickCnt <= next_tickCnt;
         usDiv <= next_usDiv;
         usTime <= next_usTime;
         ppsAge <= next_ppsAge;
         pulseLockFlag <= next_pulseLockFlag;
      end
   end

   // sentence parser and copy buffer
   gtpf_parse_t pState, next_pState;
   logic [7:0] nmeaBuf [NMEA_LEN];
   logic [6:0] charIdx, next_charIdx, wrIdx;
   logic [3:0] fieldNo, next_fieldNo;
   logic [2:0] fieldPos, next_fieldPos, tCnt, next_tCnt, dCnt, next_dCnt;
   logic [1:0] csLeft, next_csLeft;
   logic [5:0][3:0] tDig, next_tDig, dDig, next_dDig;
   logic [7:0] statChr, next_statChr;
   logic       bufWr, nmeaDone, isDigit;

   always_comb begin
      next_pState = pState;
      next_fieldNo = fieldNo;
      next_fieldPos = fieldPos;
      next_csLeft = csLeft;
      next_tDig = tDig;
      next_dDig = dDig;
      next_tCnt = tCnt;
      next_dCnt = dCnt;
      next_statChr = statChr;
      bufWr = 1'b0;
      nmeaDone = 1'b0;
      wrIdx = charIdx;
      isDigit = nmeaByte >= CH_ZERO && nmeaByte <= CH_NINE;
      if (nmeaValid && nmeaByte == CH_DOLLAR) begin
         // a new start always resyncs, even mid-sentence
         next_pState = P_BODY;
         {next_fieldNo, next_fieldPos, next_tCnt, next_dCnt} = 13'h0;
         next_statChr = 8'h00;
         wrIdx = 7'h0;
         bufWr = 1'b1;
      end else if (nmeaValid) begin
         case (pState)
            P_BODY: begin
               bufWr = 1'b1;
               if (nmeaByte == CH_COMMA) begin
                  next_fieldNo = fieldNo + 4'h1;
                  next_fieldPos = 3'h0;
               end else if (nmeaByte == CH_STAR) begin
                  next_pState = P_CSUM;
                  next_csLeft = CSUM_CHARS;
               end else begin
                  next_fieldPos = (fieldPos == 3'h7) ? fieldPos
                                                     : fieldPos + 3'h1;
                  if (fieldNo == FLD_TIME && fieldPos < DIGITS && isDigit) begin
                     next_tDig[fieldPos] = nmeaByte[3:0];
                     next_tCnt = tCnt + 3'h1;
                  end
                  if (!nmeaSelGga && fieldNo == FLD_RDATE &&
                      fieldPos < DIGITS && isDigit) begin
                     next_dDig[fieldPos] = nmeaByte[3:0];
                     next_dCnt = dCnt + 3'h1;
                  end
                  if (fieldPos == 3'h0 &&
                      fieldNo == (nmeaSelGga ? FLD_GFIX : FLD_RSTAT)) begin
                     next_statChr = nmeaByte;
                  end
               end
            end
            P_CSUM: begin
               bufWr = 1'b1;
               next_csLeft = csLeft - 2'h1;
               if (csLeft == 2'h1) begin
                  next_pState = P_IDLE;
                  nmeaDone = tCnt == DIGITS &&
                             (nmeaSelGga || dCnt == DIGITS);
               end
            end
            default: ;
         endcase
      end
      next_charIdx = (bufWr && wrIdx < 7'(NMEA_LEN)) ? wrIdx + 7'h1 : charIdx;
   end

   always_ff @(posedge ref_clk) begin
      if (bufWr && wrIdx < 7'(NMEA_LEN)) begin
         nmeaBuf[wrIdx] <= nmeaByte;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pState <= P_IDLE;
         charIdx <= 7'h0;
         {fieldNo, fieldPos, tCnt, dCnt, csLeft} <= 15'h0;
         tDig <= '0;
         dDig <= '0;
         statChr <= 8'h00;
      end else begin
         pState <= next_pState;
         charIdx <= next_charIdx;
         fieldNo <= next_fieldNo;
         fieldPos <= next_fieldPos;
         tCnt <= next_tCnt;
         dCnt <= next_dCnt;
         csLeft <= next_csLeft;
         tDig <= next_tDig;
         dDig <= next_dDig;
         statChr <= next_statChr;
      end
   end

   // time keeping
   logic [5:0][6:0] nmeaTime, next_nmeaTime, next_curTime, addOut;
   logic [31:0] nmeaAge, next_nmeaAge;
   logic [7:0]  fixStat, next_fixStat;
   logic        nmeaFresh, next_nmeaFresh, next_nmeaLocked;

   gtpf_sec_adder gtpf_sec_adder_inst (
      .inTime  (nmeaFresh ? nmeaTime : curTime),
      .outTime (addOut)
   );

   always_comb begin
      next_curTime = curTime;
      next_nmeaTime = nmeaTime;
      next_nmeaFresh = nmeaFresh;
      next_fixStat = fixStat;
      if (tick) begin
         next_curTime = addOut;
         next_nmeaFresh = 1'b0;
      end
      if (nmeaDone) begin
         // set wins over the tick's clear
         next_nmeaFresh = 1'b1;
         next_fixStat = statChr;
         next_nmeaTime[TI_HR] = dig2(tDig[0], tDig[1]);
         next_nmeaTime[TI_MI] = dig2(tDig[2], tDig[3]);
         next_nmeaTime[TI_SE] = dig2(tDig[4], tDig[5]);
         next_nmeaTime[TI_DY] = nmeaSelGga ? curTime[TI_DY]
                                           : dig2(dDig[0], dDig[1]);
         next_nmeaTime[TI_MO] = nmeaSelGga ? curTime[TI_MO]
                                           : dig2(dDig[2], dDig[3]);
         next_nmeaTime[TI_YR] = nmeaSelGga ? curTime[TI_YR]
                                           : dig2(dDig[4], dDig[5]);
      end
      next_nmeaAge = nmeaDone ? 32'h0 : nmeaAge + 32'(nmeaAge != NMEA_LOSS);
      next_nmeaLocked = nmeaDone |
                        (nmeaLocked && nmeaAge != NMEA_LOSS);
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         curTime <= {7'h00, 7'h00, 7'h00, INIT_DY, INIT_MO, INIT_YR};
         nmeaTime <= '0;
         nmeaFresh <= 1'b0;
         fixStat <= 8'h00;
         nmeaAge <= 32'h0;
         nmeaLocked <= 1'b0;
      end else begin
         curTime <= next_curTime;
         nmeaTime <= next_nmeaTime;
         nmeaFresh <= next_nmeaFresh;
         fixStat <= next_fixStat;
         nmeaAge <= next_nmeaAge;
         nmeaLocked <= next_nmeaLocked;
      end
   end

   // frame serialiser; starts a cycle after the tick so curTime is settled
   logic [9:0] idx, next_idx, readIdx, pay;
   logic [7:0] frameByte, next_txData;
   logic [6:0] fieldVal;
   logic [2:0] item;
   logic       next_txValid, next_txLast, loadByte;

   always_comb begin
      pay = readIdx - 10'(HDR_LEN);
      item = 3'((pay - 10'(PAY_DATE)) >> 1);
      fieldVal = (item < 3'h3) ? curTime[item] : curTime[3'h3 + 3'h5 - item];
      if (readIdx < 10'(HDR_LEN)) begin
         frameByte = HDR[HDR_BITS - 1 - 8 * int'(readIdx) -: 8];
      end else if (pay < 10'(PAY_DATE)) begin
         frameByte = pay[0] ? MARKER[7:0] : MARKER[15:8];
      end else if (pay < 10'(PAY_RSV)) begin
         // first byte of each pair carries the ones digit
         frameByte = CH_ZERO + 8'(pay[0] ? fieldVal / 7'ha
                                         : fieldVal % 7'ha);
      end else if (pay < 10'(PAY_NMEA)) begin
         frameByte = 8'h00;
      end else if (pay < 10'(PAY_FILL)) begin
         // bytes past the stored sentence read as zero
         frameByte = (7'(pay - 10'(PAY_NMEA)) < charIdx) ?
                     nmeaBuf[7'(pay - 10'(PAY_NMEA))] : 8'h00;
      end else if (pay < 10'(PAY_STAT)) begin
         frameByte = FILL_BYTE;
      end else if (pay == 10'(PAY_STAT)) begin
         frameByte = nmeaLocked ? fixStat : 8'h00;
      end else if (pay == 10'(PAY_LOCK)) begin
         frameByte = {7'h0, pulseLockFlag};
      end else begin
         frameByte = 8'h00;
      end
   end

   always_comb begin
      next_txValid = txValid;
      next_txLast = txLast;
      next_idx = idx;
      loadByte = 1'b0;
      readIdx = idx + 10'h1;
      if (!txValid) begin
         readIdx = 10'h0;
         if (tickDly) begin
            next_txValid = 1'b1;
            next_idx = 10'h0;
            next_txLast = 1'b0;
            loadByte = 1'b1;
         end
      end else if (txReady) begin
         if (txLast) begin
            next_txValid = 1'b0;
         end else begin
            next_idx = readIdx;
            next_txLast = readIdx == 10'(FRAME_LEN - 1);
            loadByte = 1'b1;
         end
      end
      next_txData = loadByte ? frameByte : txData;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         txValid <= 1'b0;
         txLast <= 1'b0;
         txData <= 8'h00;
         idx <= 10'h0;
      end else begin
         txValid <= next_txValid;
         txLast <= next_txLast;
         txData <= next_txData;
         idx <= next_idx;
      end
   end

   default clocking gtpf_cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_tick_frame: assert property (
      tickDly && !txValid |=> txValid && idx == 10'h0 && txData == 8'hff)
      else $error("tick did not start a frame");
   a_pps_tick: assert property (
      ppsRise |=> tick && tickCnt == 32'h0)
      else $error("pps did not realign tick");
   a_us_clear: assert property (
      ppsRise |=> usTime == 32'h0)
      else $error("microsecond time not cleared");
   a_nmea_plus: assert property (
      tick && nmeaFresh && nmeaTime[TI_SE] < SEC_MAX
      |=> curTime[TI_SE] == $past(nmeaTime[TI_SE]) + 7'h01)
      else $error("stamp is not sentence time plus one");
   a_free_run: assert property (
      tick && !nmeaFresh && curTime[TI_SE] < SEC_MAX
      |=> curTime[TI_SE] == $past(curTime[TI_SE]) + 7'h01)
      else $error("free-running time did not advance");
   a_fresh_set: assert property (
      nmeaDone |=> nmeaFresh && nmeaLocked)
      else $error("valid sentence not taken");
   a_nmea_lost: assert property (
      nmeaAge == NMEA_LOSS && !nmeaDone |=> !nmeaLocked)
      else $error("sentence lock not dropped");
   a_dest_mac: assert property (
      txValid && idx < 10'h6 |-> txData == 8'hff)
      else $error("destination MAC not broadcast");
   a_dest_ip: assert property (
      txValid && idx >= 10'h1e && idx < 10'h22 |-> txData == 8'hff)
      else $error("destination IP not broadcast");
   a_udp_len: assert property (
      txValid && (idx == 10'h26 || idx == 10'h27)
      |-> txData == (idx[0] ? UDP_LEN[7:0] : UDP_LEN[15:8]))
      else $error("udp length wrong");
   a_ip_csum: assert property (
      txValid && (idx == 10'h18 || idx == 10'h19)
      |-> txData == (idx[0] ? IP_CSUM[7:0] : IP_CSUM[15:8]))
      else $error("ip checksum wrong");
   a_fill_byte: assert property (
      txValid && idx >= 10'(HDR_LEN + PAY_FILL)
      && idx < 10'(HDR_LEN + PAY_STAT) |-> txData == FILL_BYTE)
      else $error("reserved fill wrong");
   a_hold_stall: assert property (
      txValid && !txReady |=> txValid && $stable(txData) && $stable(idx))
      else $error("frame byte changed under stall");

   c_frame_done: cover property (txValid && txReady && txLast);
   c_pps_lock: cover property ($rose(pulseLockFlag));
   c_nmea_tick: cover property (nmeaDone ##[1:1000] tick);
   c_nmea_loss: cover property ($fell(nmeaLocked));
endmodule
`default_nettype wire

/* File: hw/gtpf_pkg.sv */
package gtpf_pkg;
   // clock and time figures
   localparam longint CLK_PERIOD_PS  = 64'd5000;
   localparam longint PS_PER_MS      = 64'd1000000000;
   localparam longint PS_PER_US      = 64'd1000000;
   localparam longint TICK_PERIOD_MS = 64'd1000;
   localparam longint NMEA_LOSS_MS   = 64'd2000;
   localparam longint PPS_LOSS_MS    = 64'd1500;
   localparam int TICK_CYC_DEF =
      int'(TICK_PERIOD_MS * PS_PER_MS / CLK_PERIOD_PS);
   localparam int NMEA_CYC_DEF =
      int'(NMEA_LOSS_MS * PS_PER_MS / CLK_PERIOD_PS);
   localparam int PPS_CYC_DEF  = int'(PPS_LOSS_MS * PS_PER_MS / CLK_PERIOD_PS);
   localparam logic [7:0] US_CYC = 8'(PS_PER_US / CLK_PERIOD_PS);

   // time fields, index into a [5:0][6:0] time word
   localparam int TI_YR = 0;
   localparam int TI_MO = 1;
   localparam int TI_DY = 2;
   localparam int TI_HR = 3;
   localparam int TI_MI = 4;
   localparam int TI_SE = 5;
   localparam logic [6:0] INIT_YR = 7'h14;
   localparam logic [6:0] INIT_MO = 7'h05;
   localparam logic [6:0] INIT_DY = 7'h14;
   localparam logic [6:0] SEC_MAX = 7'h3b;
   localparam logic [6:0] MIN_MAX = 7'h3b;
   localparam logic [6:0] HR_MAX  = 7'h17;
   localparam logic [6:0] MON_MAX = 7'h0c;
   localparam logic [6:0] YR_MAX  = 7'h63;

   // frame layout, PAY_* byte indices from the first payload byte
   localparam int FRAME_LEN = 554;
   localparam int HDR_LEN   = 42;
   localparam int PAY_DATE  = 2;
   localparam int PAY_RSV   = 14;
   localparam int PAY_NMEA  = 18;
   localparam int NMEA_LEN  = 100;
   localparam int PAY_FILL  = 118;
   localparam int PAY_STAT  = 506;
   localparam int PAY_LOCK  = 507;
   localparam logic [15:0] ETHERTYPE  = 16'h0800;
   localparam logic [7:0]  IP_VER     = 8'h45;
   localparam logic [15:0] IP_TOTLEN  = 16'h021c;
   localparam logic [7:0]  IP_TTL     = 8'h40;
   localparam logic [7:0]  IP_PROTO   = 8'h11;
   localparam logic [31:0] DST_IP     = 32'hffffffff;
   localparam logic [15:0] UDP_SRC    = 16'h2710;
   localparam logic [15:0] UDP_DST    = 16'h277e;
   localparam logic [15:0] UDP_LEN    = 16'h0208;
   localparam logic [15:0] MARKER     = 16'hffee;
   localparam logic [7:0]  FILL_BYTE  = 8'hdf;

   // sentence characters and fields
   localparam logic [7:0] CH_DOLLAR = 8'h24;
   localparam logic [7:0] CH_COMMA  = 8'h2c;
   localparam logic [7:0] CH_STAR   = 8'h2a;
   localparam logic [7:0] CH_ZERO   = 8'h30;
   localparam logic [7:0] CH_NINE   = 8'h39;
   localparam logic [3:0] FLD_TIME  = 4'h1;
   localparam logic [3:0] FLD_RSTAT = 4'h2;
   localparam logic [3:0] FLD_GFIX  = 4'h6;
   localparam logic [3:0] FLD_RDATE = 4'h9;
   localparam logic [2:0] DIGITS    = 3'h6;
   localparam logic [1:0] CSUM_CHARS = 2'h2;

   typedef enum logic [1:0] {P_IDLE, P_BODY, P_CSUM} gtpf_parse_t;

   function automatic logic [15:0] gtpf_ip_csum(input logic [31:0] src);
      logic [31:0] s;
      s = 32'({IP_VER, 8'h00}) + 32'(IP_TOTLEN) + 32'({IP_TTL, IP_PROTO})
        + 32'(src[31:16]) + 32'(src[15:0])
        + 32'(DST_IP[31:16]) + 32'(DST_IP[15:0]);
      s = 32'(s[15:0]) + 32'(s[31:16]);
      s = 32'(s[15:0]) + 32'(s[31:16]);
      return ~s[15:0];
   endfunction
endpackage

/* File: hw/gtpf_sec_adder.sv */
`timescale 1ns/1ps
`default_nettype none
// adds one second to a two-digit-year calendar time, leap years by year % 4
module gtpf_sec_adder
   import gtpf_pkg::*;
(
   // time in and out, fields indexed by TI_*
   input  wire logic [5:0][6:0] inTime,
   output logic      [5:0][6:0] outTime
);
   function automatic logic [6:0] days_in(input logic [6:0] yr,
                                          input logic [6:0] mo);
      case (mo)
         7'h02:   days_in = (yr[1:0] == 2'h0) ? 7'h1d : 7'h1c;
         7'h04, 7'h06, 7'h09, 7'h0b: days_in = 7'h1e;
         default: days_in = 7'h1f;
      endcase
   endfunction

   always_comb begin
      outTime = inTime;
      if (inTime[TI_SE] < SEC_MAX) begin
         outTime[TI_SE] = inTime[TI_SE] + 7'h01;
      end else begin
         outTime[TI_SE] = 7'h00;
         if (inTime[TI_MI] < MIN_MAX) begin
            outTime[TI_MI] = inTime[TI_MI] + 7'h01;
         end else begin
            outTime[TI_MI] = 7'h00;
            if (inTime[TI_HR] < HR_MAX) begin
               outTime[TI_HR] = inTime[TI_HR] + 7'h01;
            end else begin
               outTime[TI_HR] = 7'h00;
               if (inTime[TI_DY] < days_in(inTime[TI_YR], inTime[TI_MO])) begin
                  outTime[TI_DY] = inTime[TI_DY] + 7'h01;
               end else begin
                  outTime[TI_DY] = 7'h01;
                  if (inTime[TI_MO] < MON_MAX) begin
                     outTime[TI_MO] = inTime[TI_MO] + 7'h01;
                  end else begin
                     outTime[TI_MO] = 7'h01;
                     outTime[TI_YR] = (inTime[TI_YR] < YR_MAX) ?
                                      inTime[TI_YR] + 7'h01 : 7'h00;
                  end
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: bench/gtpf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// network host: takes frame bytes under random back-pressure
module gtpf_host_model (
   // frame stream from the framer
   input  wire logic       ref_clk,
   input  wire logic       txValid,
   input  wire logic [7:0] txData,
   input  wire logic       txLast,
   output logic            txReady
);
   logic [7:0] frame [554];
   int         idx = 0;
   int         lastIdx = 0;
   int         frames = 0;
   initial txReady = 1'b0;
   // a quarter of cycles stall, so held bytes get exercised
   always @(negedge ref_clk) txReady <= ($urandom % 4) != 0;
   always @(posedge ref_clk) begin
      if (txValid && txReady) begin
         if (idx < 554) frame[idx] <= txData;
         if (txLast) lastIdx <= idx;
         if (txLast) frames <= frames + 1;
         idx <= txLast ? 0 : idx + 1;
      end
   end
endmodule
`default_nettype wire

/* File: bench/gps_time_packet_framer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_time_packet_framer_test;
   import gtpf_pkg::*;
   localparam logic [47:0] MAC = 48'h02_00_00_00_00_01; // arbitrary
   localparam logic [31:0] SIP = 32'hc0a801c9;
   logic            ref_clk = 1'b0;
   logic            reset = 1'b1;
   logic            ppsPin = 1'b0;
   logic            nmeaValid = 1'b0;
   logic [7:0]      nmeaByte = 8'h00;
   logic            nmeaSelGga = 1'b0;
   logic            txReady, txValid, txLast, pulseLockFlag, nmeaLocked;
   logic [7:0]      txData;
   logic [31:0]     usTime;
   logic [5:0][6:0] curTime;
   logic [15:0]     cs;
   int              num_errors = 0;
   int              total_checks = 0;
   int              t [6];
   int              stat, lock, hh, mi, se;
   string           nm = "";
   gtpf_framer #(.TICK_CYCLES(2000), .NMEA_LOSS(4000), .PPS_LOSS(3000),
      .SRC_MAC(MAC), .SRC_IP(SIP)) gtpf_framer_inst (.ref_clk(ref_clk),
      .reset(reset), .ppsPin(ppsPin), .nmeaValid(nmeaValid),
      .nmeaByte(nmeaByte), .nmeaSelGga(nmeaSelGga), .txReady(txReady),
      .txValid(txValid), .txData(txData), .txLast(txLast),
      .usTime(usTime), .curTime(curTime),
      .pulseLockFlag(pulseLockFlag), .nmeaLocked(nmeaLocked));
   gtpf_host_model gtpf_host_model_inst (.ref_clk(ref_clk),
      .txValid(txValid), .txData(txData), .txLast(txLast),
      .txReady(txReady));
   initial forever #2.5 ref_clk = ~ref_clk;
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(logic [63:0] seen, logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_frame();
      int n;
      n = gtpf_host_model_inst.frames;
      for (int k = 0; k < 8000 && gtpf_host_model_inst.frames == n; k++)
         @(negedge ref_clk);
      if (gtpf_host_model_inst.frames == n) begin
         num_errors++;
         conclude();
      end
   endtask
   // hours stay below 24 in every scenario, so no day carry
   function automatic void inc();
      int s;
      s = t[3] * 3600 + t[4] * 60 + t[5] + 1;
      t[3] = s / 3600;
      t[4] = s / 60 % 60;
      t[5] = s % 60;
   endfunction
   function automatic logic [7:0] eb(int i);
      int p, k, v;
      logic [239:0] h;
      p = i - 42;
      k = (p - 2) / 2;
      h = {16'h0800, 32'h4500021c, 32'h0, 16'h4011, cs, SIP,
           32'hffffffff, 48'h2710277e0208, 16'h0};
      if (i < 6) return 8'hff;
      if (i < 12) return MAC[8*(11-i)+:8];
      if (i < 42) return h[8*(41-i)+:8];
      if (p < 2) return p == 0 ? 8'hff : 8'hee;
      if (p < 14) begin
         v = t[k < 3 ? k : 8 - k];
         return 8'(((p % 2) == 0 ? v % 10 : v / 10) + 48);
      end
      if (p < 18) return 8'h00;
      if (p < 118) return p - 18 < nm.len() ? nm[p-18] : 8'h00;
      if (p < 506) return 8'hdf;
      if (p == 506) return 8'(stat);
      return p == 507 ? 8'(lock) : 8'h00;
   endfunction
   task automatic cmp(int a, int b);
      for (int i = a; i < b; i++)
         chk(gtpf_host_model_inst.frame[i], eb(i));
   endtask
   task automatic check_frame();
      chk(gtpf_host_model_inst.lastIdx, 553);
      cmp(0, 42);
      cmp(42, 60);
      cmp(60, 554);
      chk(curTime, {7'(t[5]), 7'(t[4]), 7'(t[3]),
                    7'(t[2]), 7'(t[1]), 7'(t[0])});
   endtask
   task automatic send(string s);
      nm = s;
      for (int i = 0; i < s.len(); i++) begin
         @(negedge ref_clk);
         nmeaValid = 1'b1;
         nmeaByte = s[i];
      end
      @(negedge ref_clk);
      nmeaValid = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(nmeaLocked, 1);
   endtask
   task automatic pps();
      @(negedge ref_clk);
      ppsPin = 1'b1;
      for (int k = 0; k < 12 && txValid !== 1'b1; k++) @(negedge ref_clk);
      chk(txValid, 1);
      chk(usTime, 0);
      chk(pulseLockFlag, 1);
      ppsPin = 1'b0;
      wait_frame();
      inc();
   endtask
   initial begin
      logic [31:0] sum;
      void'($urandom(66287));
      sum = 32'h4500 + 32'h021c + 32'h4011 + SIP[31:16] + SIP[15:0];
      sum = sum + 32'h1fffe;
      sum = sum[15:0] + sum[31:16];
      sum = sum[15:0] + sum[31:16];
      cs = ~sum[15:0];
      t = '{20, 5, 20, 0, 0, 0};
      stat = 0;
      lock = 0;
      repeat (5) @(negedge ref_clk);
      reset = 1'b0;
      repeat (2) begin
         wait_frame();
         inc();
         check_frame();
      end
      $display("test free_run done");
      lock = 1;
      pps();
      check_frame();
      hh = $urandom % 23;
      mi = $urandom % 60;
      se = $urandom % 60;
      // the pulse came first, the sentence follows it
      send($sformatf("$GPRMC,%02d%02d%02d,A,3027.3680,N,11423.6975,%s",
         hh, mi, se, "E,000.0,316.7,160617,004.1,W*67"));
      t = '{17, 6, 16, hh, mi, se};
      stat = 8'h41;
      pps();
      check_frame();
      $display("test rmc done");
      nmeaSelGga = 1'b1;
      send("$GPGGA,123519,4807.038,N,01131.000,E,2,08,0.9,,*47");
      t[3] = 12;
      t[4] = 35;
      t[5] = 19;
      stat = 8'h32;
      pps();
      check_frame();
      $display("test gga done");
      repeat (3) begin
         wait_frame();
         inc();
      end
      stat = 0;
      lock = 0;
      check_frame();
      chk(nmeaLocked, 0);
      chk(pulseLockFlag, 0);
      $display("test loss done");
      conclude();
   end
endmodule
`default_nettype wire
